// File: shared/dlsc_cfg.svh
/*
  Constants of the directed link speed change sequencer.
  Assumes inclusion by bare name from the package and logic files.
*/
`ifndef DLSC_CFG_SVH
`define DLSC_CFG_SVH
`define DLSC_RATE_W 1
`define DLSC_RATE_SLOW 1'h0
`define DLSC_TRAIN_W 6
`define DLSC_TRAIN_L0 6'h16
`define DLSC_TRAIN_RCV_IDLE 6'h20
`define DLSC_REQ_W 2
`define DLSC_REQ_WIDTH_BIT 0
`define DLSC_REQ_SPEED_BIT 1
`define DLSC_STAT_W 3
`define DLSC_STAT_IDLE 3'h0
`define DLSC_STAT_BUSY 3'h1
`define DLSC_STAT_DONE 3'h2
`define DLSC_STAT_LINK_LOST 3'h3
`define DLSC_STAT_ABORT_STATE 3'h4
`define DLSC_STAT_ABORT_SAME 3'h5
`define DLSC_STAT_ABORT_CAP 3'h6
`endif

// File: shared/dlsc_pkg.sv
/*
  Types of the directed link speed change sequencer.
  Assumes the constants header is on the include path.
*/
`include "dlsc_cfg.svh"
package dlsc_pkg;
  typedef enum logic [1:0] {
    DLSC_IDLE,
    DLSC_CHECK,
    DLSC_WAIT,
    DLSC_FINISH
  } dlsc_state_type;

  typedef struct packed {
    dlsc_state_type state;
    logic [`DLSC_RATE_W-1:0] rate;
    logic speed_req;
    logic [`DLSC_STAT_W-1:0] status;
    logic done;
  } dlsc_regs_type;
endpackage

// File: logic/dlsc_sequencer.sv
/*
  Directed link speed change sequencer between application control and the PCIe core.
  Assumes all inputs are synchronous to the user clock and the link reset drives nrst.
*/
// What this block does
// - Change only when link is active and training state is L0.
// - Request only when requested rate differs from current rate.
// - At slow rate, need local and partner fast capability, else abort.
// - Drive requested rate out and set request vector bit 1.
// - Hold request until Recovery.Idle or link loss.
// - Then clear request vector bit 1.
// - In the same cycle, write the outcome into the status register.
// - Changes also require device power state D0.
// - Bit 0 belongs to width changes and passes through independently.
`timescale 1ns/1ps
`include "dlsc_cfg.svh"
module dlsc_sequencer (
  input wire logic clock,
  input wire logic nrst,
  input wire logic start,
  input wire logic [`DLSC_RATE_W-1:0] target_rate,
  input wire logic width_change_request,
  input wire logic link_up,
  input wire logic power_state_d0,
  input wire logic [`DLSC_TRAIN_W-1:0] training_state,
  input wire logic [`DLSC_RATE_W-1:0] current_rate,
  input wire logic local_fast_rate_capable,
  input wire logic partner_fast_rate_capable,
  output logic [`DLSC_RATE_W-1:0] directed_rate_out,
  output logic [`DLSC_REQ_W-1:0] directed_change_request,
  output logic busy,
  output logic done,
  output logic [`DLSC_STAT_W-1:0] status
);
  import dlsc_pkg::*;

  dlsc_regs_type regs_r;
  dlsc_regs_type regs_nxt;
  logic link_ready;
  logic rate_differs;
  logic caps_ok;
  logic wait_over;
  logic [`DLSC_STAT_W-1:0] check_code;
  logic [`DLSC_STAT_W-1:0] wait_code;

  // A change is only safe from L0 with the function powered, so all three are required.
  function automatic logic dlsc_link_ok(
    input logic link_active,
    input logic power_d0,
    input logic [`DLSC_TRAIN_W-1:0] train_code
  );
    logic ok;
    ok = link_active && power_d0;
    ok = ok && (train_code == `DLSC_TRAIN_L0);
    return ok;
  endfunction

  // Equal rates give no request, so a repeated setting costs no retraining.
  function automatic logic dlsc_rates_differ(
    input logic [`DLSC_RATE_W-1:0] wanted,
    input logic [`DLSC_RATE_W-1:0] running
  );
    logic differ;
    differ = (wanted != running);
    return differ;
  endfunction

  // The capability flags matter only when leaving the slow rate.
  function automatic logic dlsc_caps_allow(
    input logic [`DLSC_RATE_W-1:0] running,
    input logic local_cap,
    input logic partner_cap
  );
    logic allow;
    allow = 1'b1;
    if (running == `DLSC_RATE_SLOW) begin
      allow = local_cap && partner_cap;
    end
    return allow;
  endfunction

  // Whichever exit comes first ends the wait.
  function automatic logic dlsc_wait_ends(
    input logic link_active,
    input logic [`DLSC_TRAIN_W-1:0] train_code
  );
    logic ends;
    ends = !link_active;
    ends = ends || (train_code == `DLSC_TRAIN_RCV_IDLE);
    return ends;
  endfunction

  // The check order fixes which abort code software sees when several checks fail.
  function automatic logic [`DLSC_STAT_W-1:0] dlsc_check_result(
    input logic ready,
    input logic differ,
    input logic allow
  );
    logic [`DLSC_STAT_W-1:0] code;
    code = `DLSC_STAT_BUSY;
    if (!ready) begin
      code = `DLSC_STAT_ABORT_STATE;
    end else if (!differ) begin
      code = `DLSC_STAT_ABORT_SAME;
    end else if (!allow) begin
      code = `DLSC_STAT_ABORT_CAP;
    end
    return code;
  endfunction

  // Link loss during the wait is reported apart, as the new rate was never confirmed.
  function automatic logic [`DLSC_STAT_W-1:0] dlsc_wait_result(
    input logic link_active
  );
    logic [`DLSC_STAT_W-1:0] code;
    code = `DLSC_STAT_LINK_LOST;
    if (link_active) begin
      code = `DLSC_STAT_DONE;
    end
    return code;
  endfunction

  assign link_ready = dlsc_link_ok(
    link_up,
    power_state_d0,
    training_state
  );
  assign rate_differs = dlsc_rates_differ(
    regs_r.rate,
    current_rate
  );
  assign caps_ok = dlsc_caps_allow(
    current_rate,
    local_fast_rate_capable,
    partner_fast_rate_capable
  );
  assign check_code = dlsc_check_result(
    link_ready,
    rate_differs,
    caps_ok
  );
  assign wait_over = dlsc_wait_ends(
    link_up,
    training_state
  );
  assign wait_code = dlsc_wait_result(link_up);

  always_comb begin
    regs_nxt = regs_r;
    regs_nxt.done = 1'b0;
    unique case (regs_r.state)
      DLSC_IDLE: begin
        if (start) begin
          regs_nxt.rate = target_rate;
          regs_nxt.status = `DLSC_STAT_BUSY;
          regs_nxt.state = DLSC_CHECK;
        end
      end
      DLSC_CHECK: begin
        regs_nxt.state = DLSC_FINISH;
        regs_nxt.status = check_code;
        if (check_code == `DLSC_STAT_BUSY) begin
          regs_nxt.speed_req = 1'b1;
          regs_nxt.state = DLSC_WAIT;
        end else begin
          regs_nxt.speed_req = 1'b0;
        end
      end
      DLSC_WAIT: begin
        if (wait_over) begin
          regs_nxt.speed_req = 1'b0;
          regs_nxt.status = wait_code;
          regs_nxt.state = DLSC_FINISH;
        end
      end
      DLSC_FINISH: begin
        regs_nxt.done = 1'b1;
        regs_nxt.state = DLSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      regs_r <= '{
        state: DLSC_IDLE,
        rate: `DLSC_RATE_SLOW,
        speed_req: 1'b0,
        status: `DLSC_STAT_IDLE,
        done: 1'b0
      };
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // The width bit is passed straight through so both changes may be requested together.
  // width bit separate
  always_comb begin
    directed_change_request = '0;
    directed_change_request[`DLSC_REQ_WIDTH_BIT] = width_change_request;
    directed_change_request[`DLSC_REQ_SPEED_BIT] = regs_r.speed_req;
  end

  assign directed_rate_out = regs_r.rate;
  assign busy = (regs_r.state != DLSC_IDLE);
  assign done = regs_r.done;
  assign status = regs_r.status;
endmodule

// File: testbench/dlsc_sequencer_asserts.sv
/* Checker on the sequencer ports. Assumes a bind to dlsc_sequencer. */
`timescale 1ns/1ps
`include "dlsc_cfg.svh"
module dlsc_sequencer_asserts (
  input wire logic clock,
  input wire logic nrst,
  input wire logic width_change_request,
  input wire logic link_up,
  input wire logic power_state_d0,
  input wire logic [5:0] training_state,
  input wire logic current_rate,
  input wire logic local_fast_rate_capable,
  input wire logic partner_fast_rate_capable,
  input wire logic directed_rate_out,
  input wire logic [1:0] directed_change_request,
  input wire logic done,
  input wire logic [2:0] status
);
  wire q = directed_change_request[1];
  wire ex = training_state == `DLSC_TRAIN_RCV_IDLE || !link_up;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  chk_width_bit: assert property (directed_change_request[0] == width_change_request)
    else $error("width bit");
  chk_needs_l0: assert property ($rose(q) |->
    $past(link_up && power_state_d0 && training_state == `DLSC_TRAIN_L0))
    else $error("not L0");
  chk_rate_differs: assert property ($rose(q) |-> directed_rate_out != $past(current_rate))
    else $error("same rate");
  chk_slow_caps: assert property ($rose(q) && !$past(current_rate) |->
    $past(local_fast_rate_capable && partner_fast_rate_capable))
    else $error("caps");
  chk_hold_req: assert property (q && !ex |=> q)
    else $error("dropped");
  chk_clear_req: assert property (q && ex |=> !q)
    else $error("held");
  chk_final_status: assert property ($fell(q) |->
    status inside {`DLSC_STAT_DONE, `DLSC_STAT_LINK_LOST} ##1 done)
    else $error("status");
  chk_abort_quiet: assert property (status > `DLSC_STAT_LINK_LOST |-> !q)
    else $error("abort");
  cover property ($rose(q));
  cover property (done && status == `DLSC_STAT_DONE);
  cover property (done && status == `DLSC_STAT_LINK_LOST);
  cover property (done && status == `DLSC_STAT_ABORT_CAP);
endmodule

// File: testbench/dlsc_core_model.sv
/* Far-end core model. Assumes the sequencer clock. */
`timescale 1ns/1ps
`include "dlsc_cfg.svh"
module dlsc_core_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic req,
  input wire logic rate,
  input wire logic [3:0] lag,
  output logic [5:0] training_state,
  output logic current_rate
);
  logic [3:0] n_r;
  // Recovery idle lasts one cycle, the least a sequencer may see.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      training_state <= `DLSC_TRAIN_L0;
      current_rate <= `DLSC_RATE_SLOW;
      n_r <= 4'h0;
    end else if (req && training_state != `DLSC_TRAIN_RCV_IDLE) begin
      n_r <= n_r + 4'h1;
      training_state <= n_r == lag ? `DLSC_TRAIN_RCV_IDLE : 6'h0D;
      if (n_r == lag) begin
        current_rate <= rate;
      end
    end else begin
      training_state <= `DLSC_TRAIN_L0;
      n_r <= 4'h0;
    end
  end
endmodule

// File: testbench/directed_link_speed_change_test.sv
/* Random bench for the sequencer. Assumes model and checker compile first. */
`timescale 1ns/1ps
`include "dlsc_cfg.svh"
bind dlsc_sequencer dlsc_sequencer_asserts dlsc_sequencer_asserts_i (.*);
module directed_link_speed_change_test;
  logic clock = 0, nrst = 0, start = 0, target_rate = 0, width_change_request = 0, link_up = 1, power_state_d0 = 1;
  logic local_fast_rate_capable = 0, partner_fast_rate_capable = 0, current_rate, directed_rate_out, busy, done;
  logic [5:0] training_state;
  logic [3:0] lag = 0;
  logic [1:0] directed_change_request;
  logic [2:0] status, x, q[$];
  logic qr[$], qw[$];
  logic [15:0] r;
  int failures = 0, n_compared = 0, cyc = 0;
  dlsc_sequencer dlsc_sequencer_i (.*);
  dlsc_core_model dlsc_core_model_i (.clock, .nrst, .req(directed_change_request[1]), .rate(directed_rate_out),
    .lag, .training_state, .current_rate);
  task summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    if (++cyc == 20000) begin
      $display("MISMATCH cycles exp below %0d got %0d", 20000, cyc);
      failures++;
      summarize();
    end else if (nrst && done === 1'b1) begin
      n_compared++;
      if (status !== q[0]) begin
        $display("MISMATCH status exp %0h got %0h", q[0], status);
        failures++;
      end
      if (directed_rate_out !== qr[0]) begin
        $display("MISMATCH directed_rate_out exp %0h got %0h", qr[0], directed_rate_out);
        failures++;
      end
      if (directed_change_request[0] !== qw[0]) begin
        $display("MISMATCH width_bit exp %0h got %0h", qw[0], directed_change_request[0]);
        failures++;
      end
      void'(q.pop_front());
      void'(qr.pop_front());
      void'(qw.pop_front());
    end
  end
  initial begin
    void'($urandom(43928));
    repeat (10) @(posedge clock);
    nrst <= 1;
    repeat (60) begin
      @(posedge clock);
      r = 16'($urandom);
      {start, target_rate, width_change_request, link_up, power_state_d0} <= {1'b1, r[0], r[1], |r[3:2], |r[5:4]};
      {local_fast_rate_capable, partner_fast_rate_capable} <= {|r[7:6], |r[9:8]};
      lag <= r[11] ? 4'hF : r[15:12];
      x = !(|r[3:2] && |r[5:4]) ? `DLSC_STAT_ABORT_STATE :
        r[0] == current_rate ? `DLSC_STAT_ABORT_SAME :
        !current_rate && !(|r[7:6] && |r[9:8]) ? `DLSC_STAT_ABORT_CAP :
        r[11] ? `DLSC_STAT_LINK_LOST : `DLSC_STAT_DONE;
      q.push_back(x);
      qr.push_back(r[0]);
      qw.push_back(r[1]);
      @(posedge clock);
      start <= 0;
      repeat (2) @(posedge clock);
      if (r[11]) link_up <= 0;
      while (busy !== 1'b0) @(posedge clock);
    end
    repeat (5) @(posedge clock);
    if (q.size() != 0) begin
      $display("MISMATCH pending_results exp 0 got %0d", q.size());
      failures++;
    end
    summarize();
  end
endmodule
